// File: rtl/runtime_status_shadow_regs.sv
// runtime event status, forced media change and shadow registers on Avalon-MM
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "rt_shadow_regs.svh"

// Functional notes
// - writing one clears an event status bit, writing zero leaves it
// - both rising and falling pin transitions set the event bit
// - bits 0..2 latch gpio pins 21, 22, 41 until cleared
// - bits 3..5 latch gpio pins 43, 60, 61 until cleared
// - event status bits 7:6 read zero
// - offset 1D reads zero
// - software may set force-change bits 0 and 1, never clear them
// - step with drive0 select clears force-change 0
// - step with drive1 select clears force-change 1
// - media flag = ds0&fc0 | ds1&fc1 | external changed input
// - force-change resets to 0x01 on main power reset
// - offset 1F gives read-only copy of data-rate setting
// - rate mirror: rate 1:0, write_select_a 4:2, power-down 6, soft reset 7
// - offset 20 mirrors serial 1 queue control, bits 5:4 zero
// - receive trigger field in bits 7:6, bit 6 its lsb
module runtime_status_shadow_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic MAIN_RST_N_I,
    input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic GPIO_PIN_21_I,
    input wire logic GPIO_PIN_22_I,
    input wire logic GPIO_PIN_41_I,
    input wire logic GPIO_PIN_43_I,
    input wire logic GPIO_PIN_60_I,
    input wire logic GPIO_PIN_61_I,
    input wire logic HEAD_STEP_STROBE_N_I,
    input wire logic DRIVE0_SELECT_N_I,
    input wire logic DRIVE1_SELECT_N_I,
    input wire logic MEDIA_CHANGED_INPUT_N_I,
    input wire logic RATE_WR_I,
    input wire logic [7:0] RATE_WDATA_I,
    input wire logic SER1_QCTRL_WR_I,
    input wire logic [7:0] SER1_QCTRL_WDATA_I,
    output logic MEDIA_CHANGED_FLAG_O,
    output logic IRQ_O
);
    typedef struct packed {
        rt_shadow_pkg::bus_state_e bus;
        logic [31:0] rdata;
        logic [`EVT_BITS-1:0] evt;
        logic [`EVT_BITS-1:0] mask;
        logic [1:0] force_chg;
        logic [7:0] rate;
        logic [7:0] ser1;
        logic media;
    } regs_s;
    regs_s st_r;
    regs_s st_nxt;

    logic [`EVT_BITS-1:0] pin_edge;
    logic [`EVT_BITS-1:0] ev_clr;
    logic wr_hit;
    logic rd_hit;
    logic lane0;
    logic [`EVT_BITS-1:0] evt_q;
    logic [`EVT_BITS-1:0] wr_bits;
    logic [1:0] fc_wr;
    logic [1:0] trig_w;

    // pin order fixes status bit order
    edge_event_latch #(
        .WIDTH(`EVT_BITS)
    ) u_edges (
        .SYS_CLK_I(SYS_CLK_I),
        .RST_N_I(RST_N_I),
        .pins_i({GPIO_PIN_61_I, GPIO_PIN_60_I, GPIO_PIN_43_I,
                 GPIO_PIN_41_I, GPIO_PIN_22_I, GPIO_PIN_21_I}),
        .edge_o(pin_edge)
    );

    function automatic logic is_ofs(input logic [ADDR_W-1:0] a, input logic [7:0] o);
        is_ofs = (a == ADDR_W'(o));
    endfunction

    function automatic logic [7:0] read_mux(input regs_s s, input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (is_ofs(a, `OFS_EVT_STATUS)) begin
            v = {2'h0, s.evt};
        end else if (is_ofs(a, `OFS_GAP)) begin
            v = 8'h00;
        end else if (is_ofs(a, `OFS_FORCE_CHG)) begin
            v = {6'h00, s.force_chg};
        end else if (is_ofs(a, `OFS_RATE_MIRROR)) begin
            v = s.rate;
        end else if (is_ofs(a, `OFS_SER1_MIRROR)) begin
            v = s.ser1;
        end else if (is_ofs(a, `OFS_IRQ_MASK)) begin
            v = {2'h0, s.mask};
        end
        read_mux = v;
    endfunction

    // one wait state on every access; answer in BUS_ANSWER
    assign wr_hit = AVS_WRITE_I && (st_r.bus == rt_shadow_pkg::BUS_ANSWER);
    assign rd_hit = AVS_READ_I && (st_r.bus == rt_shadow_pkg::BUS_ANSWER);
    assign lane0 = AVS_BYTEENABLE_I[0];
    assign ev_clr = (wr_hit && lane0 && is_ofs(AVS_ADDRESS_I, `OFS_EVT_STATUS))
        ? AVS_WRITEDATA_I[`EVT_BITS-1:0] : '0;
    // taps for the checks below
    assign evt_q = st_r.evt;
    assign wr_bits = AVS_WRITEDATA_I[`EVT_BITS-1:0];
    assign fc_wr = AVS_WRITEDATA_I[1:0];
    assign trig_w = SER1_QCTRL_WDATA_I[`SER1_TRIG_HI:`SER1_TRIG_LO];

    always_comb begin
        st_nxt = st_r;
        case (st_r.bus)
            rt_shadow_pkg::BUS_IDLE: begin
                if (AVS_READ_I || AVS_WRITE_I) begin
                    st_nxt.bus = rt_shadow_pkg::BUS_ANSWER;
                    st_nxt.rdata = {24'h000000, read_mux(st_r, AVS_ADDRESS_I)};
                end
            end
            rt_shadow_pkg::BUS_ANSWER: begin
                st_nxt.bus = rt_shadow_pkg::BUS_IDLE;
            end
            default: begin
                st_nxt.bus = rt_shadow_pkg::BUS_IDLE;
            end
        endcase
        // read of status clears it; a new edge in the same cycle wins
        if (rd_hit && is_ofs(AVS_ADDRESS_I, `OFS_EVT_STATUS)) begin
            // clear only what the snapshot returned; edges after it survive
            st_nxt.evt = st_r.evt & ~st_r.rdata[`EVT_BITS-1:0];
        end else begin
            st_nxt.evt = st_r.evt & ~ev_clr;
        end
        st_nxt.evt = st_nxt.evt | pin_edge;
        if (wr_hit && lane0 && is_ofs(AVS_ADDRESS_I, `OFS_IRQ_MASK)) begin
            st_nxt.mask = AVS_WRITEDATA_I[`EVT_BITS-1:0];
        end
        // hardware clear by step plus select; software set wins if same cycle
        if (!HEAD_STEP_STROBE_N_I && !DRIVE0_SELECT_N_I) begin
            st_nxt.force_chg[0] = 1'b0;
        end
        if (!HEAD_STEP_STROBE_N_I && !DRIVE1_SELECT_N_I) begin
            st_nxt.force_chg[1] = 1'b0;
        end
        if (wr_hit && lane0 && is_ofs(AVS_ADDRESS_I, `OFS_FORCE_CHG)) begin
            st_nxt.force_chg = st_nxt.force_chg | AVS_WRITEDATA_I[1:0];
        end
        if (RATE_WR_I) begin
            st_nxt.rate = RATE_WDATA_I;
            st_nxt.rate[`RSVD_RATE_BIT] = 1'b0;
        end
        if (SER1_QCTRL_WR_I) begin
            st_nxt.ser1 = SER1_QCTRL_WDATA_I;
            st_nxt.ser1[`SER1_RSVD_HI:`SER1_RSVD_LO] = 2'h0;
        end
        // selects are active low: selected drive reads its forced bit
        st_nxt.media = (!DRIVE0_SELECT_N_I && st_nxt.force_chg[0])
            || (!DRIVE1_SELECT_N_I && st_nxt.force_chg[1])
            || !MEDIA_CHANGED_INPUT_N_I;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            st_r.bus <= rt_shadow_pkg::BUS_IDLE;
            st_r.rdata <= 32'h00000000;
            st_r.evt <= `RST_EVT_STATUS;
            st_r.mask <= `RST_IRQ_MASK;
            st_r.media <= 1'b0;
        end else begin
            st_r.bus <= st_nxt.bus;
            st_r.rdata <= st_nxt.rdata;
            st_r.evt <= st_nxt.evt;
            st_r.mask <= st_nxt.mask;
            st_r.media <= st_nxt.media;
        end
        // main power domain: mirrors and force-change reset with their owners
        if (!MAIN_RST_N_I) begin
            st_r.force_chg <= `RST_FORCE_CHG;
            st_r.rate <= `RST_RATE_MIRROR;
            st_r.ser1 <= `RST_SER1_MIRROR;
        end else begin
            st_r.force_chg <= st_nxt.force_chg;
            st_r.rate <= st_nxt.rate;
            st_r.ser1 <= st_nxt.ser1;
        end
    end

    assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I)
        && (st_r.bus != rt_shadow_pkg::BUS_ANSWER);
    assign AVS_READDATA_O = st_r.rdata;
    assign MEDIA_CHANGED_FLAG_O = st_r.media;
    assign IRQ_O = |(st_r.evt & st_r.mask);

    a_w1c_clears: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (wr_hit && lane0 && is_ofs(AVS_ADDRESS_I, `OFS_EVT_STATUS)
         && AVS_WRITEDATA_I[0] && !pin_edge[0]) |=> !st_r.evt[0])
        else $error("status bit 0 not cleared by write one");

    a_edge_sets: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        pin_edge[0] |=> st_r.evt[0])
        else $error("edge did not set status bit 0");

    sequence bus_req;
        AVS_READ_I || AVS_WRITE_I;
    endsequence
    sequence bus_quiet;
        !AVS_READ_I && !AVS_WRITE_I;
    endsequence

    sequence pin21_toggle;
        $changed(GPIO_PIN_21_I);
    endsequence
    a_pin_latch: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (pin21_toggle ##1 bus_quiet [*4]) |=> st_r.evt[0])
        else $error("pin 21 change not latched in time");

    a_pin61_latch: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        pin_edge[5] |=> st_r.evt[5])
        else $error("pin 61 change not latched");

    a_status_rsvd: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (rd_hit && is_ofs(AVS_ADDRESS_I, `OFS_EVT_STATUS)) |-> AVS_READDATA_O[7:6] == 2'h0)
        else $error("status reserved bits not zero");

    a_gap_zero: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (rd_hit && is_ofs(AVS_ADDRESS_I, `OFS_GAP)) |-> AVS_READDATA_O == 32'h00000000)
        else $error("reserved gap read nonzero");

    a_force_sticky: assert property (@(posedge SYS_CLK_I) disable iff (!MAIN_RST_N_I)
        (st_r.force_chg[0] && HEAD_STEP_STROBE_N_I) |=> st_r.force_chg[0])
        else $error("force change 0 lost without step");

    a_step_clear: assert property (@(posedge SYS_CLK_I) disable iff (!MAIN_RST_N_I)
        (!HEAD_STEP_STROBE_N_I && !DRIVE0_SELECT_N_I && !wr_hit) |=> !st_r.force_chg[0])
        else $error("step with drive 0 did not clear");

    a_media_flag: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        !MEDIA_CHANGED_INPUT_N_I |=> MEDIA_CHANGED_FLAG_O)
        else $error("external change not reflected");

    a_rate_mirror: assert property (@(posedge SYS_CLK_I) disable iff (!MAIN_RST_N_I)
        RATE_WR_I |=> st_r.rate[7:6] == $past(RATE_WDATA_I[7:6]))
        else $error("rate mirror not updated");

    a_w1c_all: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (wr_hit && lane0 && is_ofs(AVS_ADDRESS_I, `OFS_EVT_STATUS))
            |=> ((evt_q & $past(wr_bits) & ~$past(pin_edge)) == '0))
        else $error("write one left a status bit set");

    a_w0_keeps: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (wr_hit && lane0 && is_ofs(AVS_ADDRESS_I, `OFS_EVT_STATUS))
            |=> (($past(evt_q) & ~$past(wr_bits) & ~evt_q) == '0))
        else $error("write zero cleared a status bit");

    a_edge_both: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (pin_edge != '0) |=> ((evt_q & $past(pin_edge)) == $past(pin_edge)))
        else $error("edge pulse not latched in status");

    a_pin22_latch: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        ($changed(GPIO_PIN_22_I) ##1 bus_quiet [*4]) |=> st_r.evt[1])
        else $error("pin 22 change not latched in time");

    a_status_hold: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (!rd_hit && !wr_hit) |=> (($past(evt_q) & ~evt_q) == '0))
        else $error("status bit dropped without software clear");

    a_no_spurious: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (pin_edge == '0) |=> ((evt_q & ~$past(evt_q)) == '0))
        else $error("status bit set without an edge");

    a_edge_delay: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        $changed(GPIO_PIN_61_I) |-> ##3 pin_edge[5])
        else $error("pin 61 change gave no edge pulse");

    a_force1_sticky: assert property (@(posedge SYS_CLK_I) disable iff (!MAIN_RST_N_I)
        (st_r.force_chg[1] && HEAD_STEP_STROBE_N_I) |=> st_r.force_chg[1])
        else $error("force change 1 lost without step");

    a_force_set: assert property (@(posedge SYS_CLK_I) disable iff (!MAIN_RST_N_I)
        (wr_hit && lane0 && is_ofs(AVS_ADDRESS_I, `OFS_FORCE_CHG))
            |=> ((st_r.force_chg & $past(fc_wr)) == $past(fc_wr)))
        else $error("software write did not set force change");

    a_step_clear1: assert property (@(posedge SYS_CLK_I) disable iff (!MAIN_RST_N_I)
        (!HEAD_STEP_STROBE_N_I && !DRIVE1_SELECT_N_I && !wr_hit) |=> !st_r.force_chg[1])
        else $error("step with drive 1 did not clear");

    a_force_reset: assert property (@(posedge SYS_CLK_I)
        !MAIN_RST_N_I |=> (st_r.force_chg == `RST_FORCE_CHG))
        else $error("force change not reset by main reset");

    a_mirror_reset: assert property (@(posedge SYS_CLK_I)
        !MAIN_RST_N_I |=> (st_r.rate == `RST_RATE_MIRROR)
            && (st_r.ser1 == `RST_SER1_MIRROR))
        else $error("mirrors not reset by main reset");

    a_rate_fields: assert property (@(posedge SYS_CLK_I) disable iff (!MAIN_RST_N_I)
        RATE_WR_I |=> (st_r.rate == ($past(RATE_WDATA_I) & `RATE_KEEP_MASK)))
        else $error("rate mirror fields wrong");

    a_rate_ro: assert property (@(posedge SYS_CLK_I) disable iff (!MAIN_RST_N_I)
        !RATE_WR_I |=> $stable(st_r.rate))
        else $error("rate mirror changed without its strobe");

    a_ser1_fields: assert property (@(posedge SYS_CLK_I) disable iff (!MAIN_RST_N_I)
        SER1_QCTRL_WR_I |=> (st_r.ser1 == ($past(SER1_QCTRL_WDATA_I) & `SER1_KEEP_MASK)))
        else $error("serial mirror fields wrong");

    a_ser1_rsvd: assert property (@(posedge SYS_CLK_I) disable iff (!MAIN_RST_N_I)
        st_r.ser1[`SER1_RSVD_HI:`SER1_RSVD_LO] == 2'h0)
        else $error("serial mirror reserved bits set");

    a_ser1_trigger: assert property (@(posedge SYS_CLK_I) disable iff (!MAIN_RST_N_I)
        SER1_QCTRL_WR_I |=> (st_r.ser1[`SER1_TRIG_HI:`SER1_TRIG_LO] == $past(trig_w)))
        else $error("receive trigger field misplaced");

    a_ser1_ro: assert property (@(posedge SYS_CLK_I) disable iff (!MAIN_RST_N_I)
        !SER1_QCTRL_WR_I |=> $stable(st_r.ser1))
        else $error("serial mirror changed without its strobe");

    a_force_rsvd: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (rd_hit && is_ofs(AVS_ADDRESS_I, `OFS_FORCE_CHG)) |-> AVS_READDATA_O[31:2] == 30'h00000000)
        else $error("force change reserved bits not zero");

    a_media_ds1: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (!DRIVE1_SELECT_N_I && st_r.force_chg[1] && HEAD_STEP_STROBE_N_I && MAIN_RST_N_I)
            |=> MEDIA_CHANGED_FLAG_O)
        else $error("drive 1 forced change not reflected");

    a_media_idle: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (DRIVE0_SELECT_N_I && DRIVE1_SELECT_N_I && MEDIA_CHANGED_INPUT_N_I) |=> !MEDIA_CHANGED_FLAG_O)
        else $error("media flag set with no source");

    a_bus_answer: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (bus_req ##0 AVS_WAITREQUEST_O ##1 bus_req) |-> !AVS_WAITREQUEST_O)
        else $error("held request not answered in one wait state");

    a_read_clears: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (rd_hit && is_ofs(AVS_ADDRESS_I, `OFS_EVT_STATUS) && (pin_edge == '0))
            |=> ((evt_q & st_r.rdata[`EVT_BITS-1:0]) == '0))
        else $error("status read did not clear reported bits");

    a_read_keeps: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (rd_hit && is_ofs(AVS_ADDRESS_I, `OFS_EVT_STATUS))
            |=> (($past(evt_q) & ~st_r.rdata[`EVT_BITS-1:0] & ~evt_q) == '0))
        else $error("status read cleared an unreported bit");
endmodule

// File: rtl/rt_shadow_regs.svh
// register offsets, field positions and reset values of the runtime shadow bank
`ifndef RT_SHADOW_REGS_SVH
`define RT_SHADOW_REGS_SVH
`define OFS_EVT_STATUS 8'h1C
`define OFS_GAP 8'h1D
`define OFS_FORCE_CHG 8'h1E
`define OFS_RATE_MIRROR 8'h1F
`define OFS_SER1_MIRROR 8'h20
`define OFS_IRQ_MASK 8'h30
`define RST_EVT_STATUS 6'h00
`define RST_FORCE_CHG 2'h1
`define RST_RATE_MIRROR 8'h00
`define RST_SER1_MIRROR 8'h00
`define RST_IRQ_MASK 6'h00
`define EVT_BITS 6
`define RSVD_RATE_BIT 5
`define SER1_RSVD_LO 4
`define SER1_RSVD_HI 5
`define EDGE_WARM_CYCLES 2'h3
`define RATE_KEEP_MASK 8'hDF
`define SER1_KEEP_MASK 8'hCF
`define SER1_TRIG_HI 7
`define SER1_TRIG_LO 6
`endif

// File: rtl/rt_shadow_pkg.sv
// types shared by the runtime shadow bank
package rt_shadow_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_e;
endpackage

// File: rtl/edge_event_latch.sv
// synchronises event pins and flags either edge as a one-cycle pulse
`timescale 1ns/1ps
`include "rt_shadow_regs.svh"
module edge_event_latch #(
    parameter int WIDTH = 6
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic [WIDTH-1:0] pins_i,
    output logic [WIDTH-1:0] edge_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] edge_p;
        logic [1:0] warm;
    } edge_s;
    edge_s st_r;
    edge_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = pins_i;
        st_nxt.sync = st_r.meta;
        st_nxt.prev = st_r.sync;
        // first stage feeds only the second; compare after it
        // no pulse until prev holds a real sample: a pin idling high after reset
        // must not look like an edge; a change inside that window is lost
        st_nxt.warm = (st_r.warm == `EDGE_WARM_CYCLES) ? st_r.warm : st_r.warm + 2'h1;
        st_nxt.edge_p = (st_r.warm == `EDGE_WARM_CYCLES)
            ? (st_r.sync ^ st_r.prev) : '0;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign edge_o = st_r.edge_p;
endmodule

// File: sim/floppy_side_model.sv
// drive strobes and mirrored-register write strobes facing the bank
`timescale 1ns/1ps
module floppy_side_model (
    input wire logic clk_i,
    output logic step_n_o,
    output logic ds0_n_o,
    output logic ds1_n_o,
    output logic rate_wr_o,
    output logic ser_wr_o,
    output logic [7:0] wd_o
);
    initial begin
        step_n_o = 1'b1;
        ds0_n_o = 1'b1;
        ds1_n_o = 1'b1;
        rate_wr_o = 1'b0;
        ser_wr_o = 1'b0;
        wd_o = 8'h00;
    end
    // selects are levels, held until changed
    task automatic sel(input logic s0_n, input logic s1_n);
        @(posedge clk_i);
        ds0_n_o <= s0_n;
        ds1_n_o <= s1_n;
    endtask
    // one-cycle step while the select stays put
    task automatic step();
        @(posedge clk_i);
        step_n_o <= 1'b0;
        @(posedge clk_i);
        step_n_o <= 1'b1;
    endtask
    // data inverted once the strobe is gone, so a stale copy shows
    task automatic mirror(input logic ser, input logic [7:0] d);
        @(posedge clk_i);
        rate_wr_o <= !ser;
        ser_wr_o <= ser;
        wd_o <= d;
        @(posedge clk_i);
        rate_wr_o <= 1'b0;
        ser_wr_o <= 1'b0;
        wd_o <= ~d;
    endtask
endmodule

// File: sim/runtime_status_shadow_regs_bench.sv
// self-checking bench for the runtime status and shadow bank
`timescale 1ns/1ps
module runtime_status_shadow_regs_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic main_rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic waitreq, step_n, ds0_n, ds1_n, rate_wr, ser_wr, flag, irq;
    logic [7:0] wd;
    logic [5:0] gp = 6'h00;
    logic chg_n = 1'b1;
    logic [3:0] be = 4'hF;
    int errors = 0;
    int compares = 0;
    always #25 clk = ~clk;
    floppy_side_model host (.clk_i(clk), .step_n_o(step_n), .ds0_n_o(ds0_n), .ds1_n_o(ds1_n),
        .rate_wr_o(rate_wr), .ser_wr_o(ser_wr), .wd_o(wd));
    runtime_status_shadow_regs dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .MAIN_RST_N_I(main_rst_n),
        .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
        .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
        .GPIO_PIN_21_I(gp[0]), .GPIO_PIN_22_I(gp[1]), .GPIO_PIN_41_I(gp[2]),
        .GPIO_PIN_43_I(gp[3]), .GPIO_PIN_60_I(gp[4]), .GPIO_PIN_61_I(gp[5]),
        .HEAD_STEP_STROBE_N_I(step_n), .DRIVE0_SELECT_N_I(ds0_n), .DRIVE1_SELECT_N_I(ds1_n),
        .MEDIA_CHANGED_INPUT_N_I(chg_n), .RATE_WR_I(rate_wr), .RATE_WDATA_I(wd),
        .SER1_QCTRL_WR_I(ser_wr), .SER1_QCTRL_WDATA_I(wd), .MEDIA_CHANGED_FLAG_O(flag),
        .IRQ_O(irq));
    task automatic conclude();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !we;
        wr <= we;
        addr <= a;
        wdata <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) begin
            errors++;
            $display("mismatch at %0t: bus hang", $time);
            conclude();
        end
    endtask
    task automatic rck(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, {24'h000000, exp}, "read");
    endtask
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic t_reset();
        rck(8'h1C, 8'h00);
        rck(8'h1D, 8'h00);
        rck(8'h1E, 8'h01);
        rck(8'h1F, 8'h00);
        rck(8'h20, 8'h00);
        rck(8'h05, 8'h00);
        wrt(8'h1D, 8'hFF);
        rck(8'h1D, 8'h00);
    endtask
    task automatic t_events();
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            gp[i] <= 1'b1;
            repeat (6) @(posedge clk);
            rck(8'h1C, 8'h01 << i);
            @(posedge clk);
            gp[i] <= 1'b0;
            repeat (6) @(posedge clk);
            rck(8'h1C, 8'h01 << i);
        end
        rck(8'h1C, 8'h00);
        @(posedge clk);
        gp <= 6'h3F;
        repeat (6) @(posedge clk);
        wrt(8'h1C, 8'hC0);
        wrt(8'h1C, 8'h15);
        rck(8'h1C, 8'h2A);
    endtask
    task automatic t_force();
        wrt(8'h1E, 8'h00);
        rck(8'h1E, 8'h01);
        wrt(8'h1E, 8'hFE);
        rck(8'h1E, 8'h03);
        host.sel(1'b0, 1'b1);
        repeat (3) @(posedge clk);
        chk(flag, 1'b1, "flag ds0");
        host.step();
        rck(8'h1E, 8'h02);
        chk(flag, 1'b0, "flag fc0 off");
        host.sel(1'b1, 1'b0);
        repeat (3) @(posedge clk);
        chk(flag, 1'b1, "flag ds1");
        host.step();
        rck(8'h1E, 8'h00);
        @(posedge clk);
        chg_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk(flag, 1'b1, "flag ext");
        chg_n <= 1'b1;
        host.sel(1'b1, 1'b1);
    endtask
    task automatic t_mirror();
        host.mirror(1'b0, 8'hFF);
        rck(8'h1F, 8'hDF);
        host.mirror(1'b1, 8'hFF);
        rck(8'h20, 8'hCF);
        host.mirror(1'b1, 8'h40);
        rck(8'h20, 8'h40);
        @(posedge clk);
        main_rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        main_rst_n <= 1'b1;
        rck(8'h1F, 8'h00);
        rck(8'h20, 8'h00);
        rck(8'h1E, 8'h01);
    endtask
    // only bit 0 unmasked: bit 1 must not reach the line
    task automatic t_irq();
        be <= 4'hE;
        wrt(8'h30, 8'h3F);
        rck(8'h30, 8'h00);
        be <= 4'hF;
        wrt(8'h30, 8'h01);
        rck(8'h30, 8'h01);
        @(posedge clk);
        gp[1] <= 1'b0;
        repeat (6) @(posedge clk);
        chk(irq, 1'b0, "irq masked");
        gp[0] <= 1'b0;
        repeat (6) @(posedge clk);
        chk(irq, 1'b1, "irq raised");
        rck(8'h1C, 8'h03);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0, "irq cleared");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        main_rst_n <= 1'b1;
        t_reset();
        t_events();
        t_force();
        t_mirror();
        t_irq();
        conclude();
    end
endmodule
